// [cgm_params.svh]
// Constants of the base clock selector: register indices, fields, resets.
// Assumes a Wishbone slave decoding word indices from byte address bits 7:2.
`ifndef CGM_PARAMS_SVH
`define CGM_PARAMS_SVH
`define IDX_PLL_CONTROL   6'h1c
`define IDX_PLL_BANDWIDTH 6'h1d
`define IDX_PLL_PROGRAM   6'h1e
`define F_IRQ_EN          7
`define F_LOCK_FLAG       6
`define F_PLL_ON          5
`define F_BCS             4
`define F_AUTO            7
`define F_LOCK            6
`define F_ACQ             5
`define F_XLD             4
`define CTRL_LOW_NIBBLE   4'hf
`define BW_LOW_NIBBLE     4'h0
`define RST_MULT          4'h6
`define RST_RANGE         4'h6
`define SWITCH_EDGES      3
`endif

// [cgm_pkg.sv]
// Types shared by the base clock selector files.
// Assumes nothing of its surroundings.
`default_nettype none
package cgm_pkg;
   typedef logic [31:0] wb_data_t;
   typedef enum logic [0:0] {ST_RUN = 1'b0, ST_WAIT = 1'b1} sw_state_t;
endpackage : cgm_pkg
`default_nettype wire

// [cgm_pin_sync.sv]
// Two-flop synchroniser with edge detection for one pin.
// Assumes the pin is asynchronous to i_clk and slower than half its rate.
`timescale 1ns/1ns
`default_nettype none
module cgm_pin_sync (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_pin,
   output logic      o_level,
   output logic      o_rise,
   output logic      o_fall
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end
      else
      begin
         s1_q <= i_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign o_level = s2_q;
   assign o_rise  = s2_q & ~s3_q;
   assign o_fall  = ~s2_q & s3_q;
endmodule : cgm_pin_sync
`default_nettype wire

// [cgm_base_clock.sv]
// Base clock selector control with its three byte registers.
// Assumes a classic Wishbone master and analog clocks sampled as pins.
`timescale 1ns/1ns
`default_nettype none
`include "cgm_params.svh"
module cgm_base_clock #(
   parameter int SWITCH_EDGES = `SWITCH_EDGES
) (
   input  wire logic             I_CLK,
   input  wire logic             I_RST_N,
   input  wire logic             I_WB_CYC,
   input  wire logic             I_WB_STB,
   input  wire logic             I_WB_WE,
   input  wire logic [7:0]       I_WB_ADR,
   input  wire logic [3:0]       I_WB_SEL,
   input  wire cgm_pkg::wb_data_t I_WB_DAT,
   output cgm_pkg::wb_data_t     O_WB_DAT,
   output logic                  O_WB_ACK,
   input  wire logic             I_XTAL_CLK,
   input  wire logic             I_VCO_CLK,
   input  wire logic             I_LOCK,
   input  wire logic             I_ACQ_TRK,
   input  wire logic             I_OSC_EN,
   output logic                  O_BASE_CLK,
   output logic                  O_CLKGEN_IRQ,
   output logic                  O_OSC_RUN,
   output logic                  O_PLL_RUN,
   output logic                  O_AUTO_BW,
   output logic                  O_ACQ_TRACK,
   output logic [3:0]            O_FB_MULT,
   output logic [3:0]            O_VCO_RANGE
);
   import cgm_pkg::*;

   localparam logic [3:0] EDGES = 4'(SWITCH_EDGES);
   generate
      if (SWITCH_EDGES < 1 || SWITCH_EDGES > 15)
      begin : g_bad_edges
         $error("SWITCH_EDGES must lie in 1 to 15");
      end
   endgenerate
   logic [3:0] pins;
   logic [3:0] lvl;
   logic [3:0] rise;
   logic [3:0] fall;
   logic       x_rise;
   logic       v_rise;
   logic       lock_lvl;
   logic       lock_chg;
   logic       acq_lvl;
   logic       ack_q;
   logic       ack_d;
   logic       acc;
   logic [5:0] idx;
   logic       wr_ctrl;
   logic       wr_bw;
   logic       wr_prog;
   logic       acc_ctrl;
   logic       take_ctrl;
   logic [7:0] wd;
   logic [7:0] rd_d;
   wb_data_t   dat_q;
   logic       irq_en_q;
   logic       flag_q;
   logic       pll_on_q;
   logic       bcs_q;
   logic       auto_q;
   logic       acq_man_q;
   logic       xld_q;
   logic [3:0] mult_q;
   logic [3:0] range_q;
   sw_state_t  state_q;
   logic       src_q;
   logic [3:0] xcnt_q;
   logic [3:0] vcnt_q;
   logic       out_q;
   logic       sel_rise;
   logic       irq_q;
   logic       osc_run_q;
   logic       pll_run_q;

   // Pin synchronisers
   assign pins = {I_ACQ_TRK, I_LOCK, I_VCO_CLK, I_XTAL_CLK};
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_sync
         cgm_pin_sync u_cgm_pin_sync (
            .i_clk   (I_CLK),
            .i_rst_n (I_RST_N),
            .i_pin   (pins[g]),
            .o_level (lvl[g]),
            .o_rise  (rise[g]),
            .o_fall  (fall[g])
         );
      end
   endgenerate

   assign x_rise   = rise[0];
   assign v_rise   = rise[1];
   assign lock_lvl = lvl[2];
   assign lock_chg = rise[2] | fall[2];
   assign acq_lvl  = lvl[3];

   // Wishbone slave, answers one cycle after the request
   assign ack_d    = I_WB_CYC & I_WB_STB & ~ack_q;
   assign acc      = I_WB_CYC & I_WB_STB & ack_q;
   assign idx      = I_WB_ADR[7:2];
   assign wd       = I_WB_DAT[7:0];
   assign acc_ctrl = acc & (idx == `IDX_PLL_CONTROL);
   assign take_ctrl = ack_d & (idx == `IDX_PLL_CONTROL);
   assign wr_ctrl  = acc_ctrl & I_WB_WE & I_WB_SEL[0];
   assign wr_bw    = acc & I_WB_WE & I_WB_SEL[0] & (idx == `IDX_PLL_BANDWIDTH);
   assign wr_prog  = acc & I_WB_WE & I_WB_SEL[0] & (idx == `IDX_PLL_PROGRAM);
   always_comb
   begin
      case (idx)
         `IDX_PLL_CONTROL:
            rd_d = {irq_en_q & auto_q, flag_q & auto_q, pll_on_q, bcs_q,
                    `CTRL_LOW_NIBBLE};
         `IDX_PLL_BANDWIDTH:
            rd_d = {auto_q, lock_lvl & auto_q,
                    auto_q ? acq_lvl : acq_man_q,
                    xld_q & bcs_q, `BW_LOW_NIBBLE};
         `IDX_PLL_PROGRAM:
            rd_d = {mult_q, range_q};
         default:
            rd_d = 8'h00;
      endcase
   end
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
      begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end
      else
      begin
         ack_q <= ack_d;
         dat_q <= ack_d ? {24'h00_0000, rd_d} : 32'h0000_0000;
      end
   end

   assign O_WB_ACK = ack_q;
   assign O_WB_DAT = dat_q;
   // Control register
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
      begin
         irq_en_q <= 1'b0;
         flag_q   <= 1'b0;
         pll_on_q <= 1'b1;
         bcs_q    <= 1'b0;
      end
      else
      begin
         if (!auto_q)
            irq_en_q <= 1'b0;
         else if (wr_ctrl)
            irq_en_q <= wd[`F_IRQ_EN];
         if (!auto_q)
            flag_q <= 1'b0;
         else if (lock_chg)
            flag_q <= 1'b1;
         else if (take_ctrl)
            flag_q <= 1'b0;
         if (bcs_q)
            pll_on_q <= 1'b1;
         else if (wr_ctrl)
            pll_on_q <= wd[`F_PLL_ON];
         if (!I_OSC_EN || !pll_on_q || range_q == 4'h0)
            bcs_q <= 1'b0;
         else if (wr_ctrl)
            bcs_q <= wd[`F_BCS] & (wd[`F_PLL_ON] | bcs_q);
      end
   end

   // Bandwidth control register
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
      begin
         auto_q    <= 1'b0;
         acq_man_q <= 1'b0;
         xld_q     <= 1'b0;
      end
      else
      begin
         if (wr_bw)
            auto_q <= wd[`F_AUTO];
         if (wr_bw && !auto_q)
            acq_man_q <= wd[`F_ACQ];
         if (!bcs_q)
            xld_q <= 1'b0;
         else if (wr_bw && wd[`F_XLD])
            xld_q <= 1'b1;
         else if (x_rise)
            xld_q <= 1'b0;
      end
   end

   // Programming register
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
      begin
         mult_q  <= `RST_MULT;
         range_q <= `RST_RANGE;
      end
      else if (wr_prog && !pll_on_q)
      begin
         mult_q  <= wd[7:4];
         range_q <= wd[3:0];
      end
   end

   // Transition control: hold output until both sources show enough edges
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
      begin
         state_q <= ST_RUN;
         src_q   <= 1'b0;
         xcnt_q  <= 4'h0;
         vcnt_q  <= 4'h0;
      end
      else if (!I_OSC_EN)
      begin
         state_q <= ST_RUN;
         src_q   <= 1'b0;
         xcnt_q  <= 4'h0;
         vcnt_q  <= 4'h0;
      end
      else
      begin
         case (state_q)
            ST_RUN:
               if (bcs_q != src_q)
               begin
                  state_q <= ST_WAIT;
                  xcnt_q  <= 4'h0;
                  vcnt_q  <= 4'h0;
               end
            ST_WAIT:
            begin
               if (x_rise && xcnt_q < EDGES)
                  xcnt_q <= xcnt_q + 4'h1;
               if (v_rise && vcnt_q < EDGES)
                  vcnt_q <= vcnt_q + 4'h1;
               if (xcnt_q == EDGES && vcnt_q == EDGES)
               begin
                  src_q   <= bcs_q;
                  state_q <= ST_RUN;
               end
            end
            default:
               state_q <= ST_RUN;
         endcase
      end
   end

   // Divide by two: one toggle per source rising edge
   assign sel_rise = src_q ? v_rise : x_rise;

   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
         out_q <= 1'b0;
      else if (!I_OSC_EN)
         out_q <= 1'b0;
      else if (state_q == ST_RUN && sel_rise)
         out_q <= ~out_q;
   end

   // Interrupt and analog enables
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
      begin
         irq_q     <= 1'b0;
         osc_run_q <= 1'b0;
         pll_run_q <= 1'b0;
      end
      else
      begin
         irq_q     <= flag_q & irq_en_q & I_OSC_EN;
         osc_run_q <= I_OSC_EN;
         pll_run_q <= I_OSC_EN & pll_on_q & (range_q != 4'h0);
      end
   end

   assign O_BASE_CLK   = out_q;
   assign O_CLKGEN_IRQ = irq_q;
   assign O_OSC_RUN    = osc_run_q;
   assign O_PLL_RUN    = pll_run_q;
   assign O_AUTO_BW    = auto_q;
   assign O_ACQ_TRACK  = acq_man_q;
   assign O_FB_MULT    = mult_q;
   assign O_VCO_RANGE  = range_q;

   // Checks
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   property p_bcs_guard;
      bcs_q |-> pll_on_q && range_q != 4'h0;
   endproperty
   a_bcs_guard: assert property (p_bcs_guard)
      else $error("select set without PLL on or with zero range");
   property p_pll_forced;
      (bcs_q && wr_ctrl && !wd[`F_PLL_ON]) |=> pll_on_q;
   endproperty
   a_pll_forced: assert property (p_pll_forced)
      else $error("power-on cleared while VCO selected");
   property p_two_writes;
      (wr_ctrl && !pll_on_q) |=> !bcs_q;
   endproperty
   a_two_writes: assert property (p_two_writes)
      else $error("select set in the same write as power-on");
   property p_prog_locked;
      (wr_prog && pll_on_q) |=> $stable({mult_q, range_q});
   endproperty
   a_prog_locked: assert property (p_prog_locked)
      else $error("programming register changed while PLL on");
   property p_flag_set;
      (auto_q && lock_chg && !wr_bw) |=> flag_q;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("lock change did not set flag");
   property p_flag_clear;
      (take_ctrl && !lock_chg) |=> !flag_q;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("control access did not clear flag");
   property p_irq;
      ##1 O_CLKGEN_IRQ == $past(flag_q && irq_en_q && I_OSC_EN);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt does not follow flag and enable");
   property p_manual_read;
      (ack_d && !I_WB_WE && idx == `IDX_PLL_CONTROL && !auto_q && !wr_bw)
         |=> O_WB_DAT[7:6] == 2'b00 && O_WB_DAT[3:0] == `CTRL_LOW_NIBBLE;
   endproperty
   a_manual_read: assert property (p_manual_read)
      else $error("manual mode control read shows enable or flag");
   property p_hold;
      (state_q == ST_WAIT && I_OSC_EN) |=> $stable(O_BASE_CLK);
   endproperty
   a_hold: assert property (p_hold)
      else $error("base clock moved during source change");
   property p_toggle;
      (state_q == ST_RUN && sel_rise && I_OSC_EN) |=> O_BASE_CLK != $past(O_BASE_CLK);
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("base clock missed a source edge");
   property p_stop;
      !I_OSC_EN |=> !bcs_q && !O_BASE_CLK && !src_q;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop did not return to crystal source");
   c_switch_vco: cover property (state_q == ST_WAIT && bcs_q ##1 src_q);
   c_flag_set: cover property (auto_q && lock_chg ##1 flag_q);
   c_irq: cover property (O_CLKGEN_IRQ);
   c_stop: cover property (bcs_q ##1 !I_OSC_EN);
endmodule : cgm_base_clock
`default_nettype wire

// [cgm_far_side.sv]
// Far-side model: crystal and VCO sources, lock detector level, filter mode.
// Assumes one bench clock; each source period is many bench cycles.
`timescale 1ns/1ns
`default_nettype none
module cgm_far_side #(
   parameter int XTAL_HALF = 4,
   parameter int VCO_HALF  = 3
) (
   input  wire logic i_clk,
   input  wire logic i_lock_req,
   output logic      o_xtal,
   output logic      o_vco,
   output logic      o_lock,
   output logic      o_acq
);
   int   xcnt = 0;
   int   vcnt = 0;
   logic lock_d = 1'b0;
   initial
   begin
      o_xtal = 1'b0;
      o_vco  = 1'b0;
      o_lock = 1'b0;
   end
   assign o_acq = 1'b1;
   // Sources toggle on fixed counts, lock follows the request two cycles late
   always @(posedge i_clk)
   begin
      xcnt <= (xcnt == XTAL_HALF - 1) ? 0 : xcnt + 1;
      vcnt <= (vcnt == VCO_HALF - 1) ? 0 : vcnt + 1;
      if (xcnt == XTAL_HALF - 1) o_xtal <= ~o_xtal;
      if (vcnt == VCO_HALF - 1) o_vco <= ~o_vco;
      lock_d <= i_lock_req;
      o_lock <= lock_d;
   end
endmodule : cgm_far_side
`default_nettype wire

// [base_clock_selector_ctrl_bench.sv]
// Self-checking bench of the base clock selector over classic Wishbone.
// Assumes the far-side model supplies sources of 8 and 6 bench cycles.
`timescale 1ns/1ns
`default_nettype none
module base_clock_selector_ctrl_bench;
   import cgm_pkg::*;
   logic clk, rst_n, cyc, stb, we, lock_req, osc_en;
   logic [7:0] adr, r;
   logic [3:0] sel, fb_mult, vco_range;
   wb_data_t wdat, rdat;
   logic ack, base, irq, osc_run, pll_run, auto_bw, acq_tr, xtal, vco, lock, acquire_track_select;
   logic [31:0] seed;
   int errors = 0;
   int checks = 0;
   cgm_base_clock u_cgm_base_clock (.I_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc),
      .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
      .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_XTAL_CLK(xtal), .I_VCO_CLK(vco),
      .I_LOCK(lock), .I_ACQ_TRK(acquire_track_select), .I_OSC_EN(osc_en), .O_BASE_CLK(base),
      .O_CLKGEN_IRQ(irq), .O_OSC_RUN(osc_run), .O_PLL_RUN(pll_run),
      .O_AUTO_BW(auto_bw), .O_ACQ_TRACK(acq_tr), .O_FB_MULT(fb_mult),
      .O_VCO_RANGE(vco_range));
   cgm_far_side u_cgm_far_side (.i_clk(clk), .i_lock_req(lock_req), .o_xtal(xtal),
      .o_vco(vco), .o_lock(lock), .o_acq(acquire_track_select));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic test_done();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         errors++;
      end
   endtask : chk
   // One classic cycle, held until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= {24'h0, d};
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      r = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) errors++;
   endtask : bus
   task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(n, e, r);
   endtask : rd
   task automatic wait_irq(input logic e);
      int n;
      n = 0;
      while (irq !== e && n < 40)
      begin
         @(posedge clk);
         n++;
      end
      chk("irq", {7'h0, e}, {7'h0, irq});
   endtask : wait_irq
   // Width of the high and low phase of the base clock, in bench cycles
   task automatic measure(input logic [7:0] half);
      int hi, lo, n;
      hi = 0;
      lo = 0;
      n = 0;
      while (base !== 1'b0 && n < 60)
      begin
         @(posedge clk);
         n++;
      end
      while (base !== 1'b1 && n < 60)
      begin
         @(posedge clk);
         n++;
      end
      while (base === 1'b1 && hi < 60)
      begin
         @(posedge clk);
         hi++;
      end
      while (base === 1'b0 && lo < 60)
      begin
         @(posedge clk);
         lo++;
      end
      chk("base_high", half, hi[7:0]);
      chk("base_low", half, lo[7:0]);
   endtask : measure
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      test_done();
   end
   initial
   begin
      logic b;
      logic frozen;
      {rst_n, cyc, stb, we, lock_req} = 5'h0;
      osc_en = 1'b1;
      adr = 8'h00;
      sel = 4'hf;
      wdat = '0;
      seed = 32'hdb4d;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd("ctrl", 8'h70, 8'h2f);
      chk("osc_run", 8'h1, {7'h0, osc_run});
      chk("pll_run", 8'h1, {7'h0, pll_run});
      rd("bw", 8'h74, 8'h00);
      bus(1'b1, 8'h74, 8'h20);
      rd("bw", 8'h74, 8'h20);
      chk("acq_track", 8'h1, {7'h0, acq_tr});
      rd("prog", 8'h78, 8'h66);
      bus(1'b1, 8'h40, 8'hff);
      rd("unmapped", 8'h40, 8'h00);
      bus(1'b1, 8'h78, 8'h12);
      rd("prog", 8'h78, 8'h66);
      bus(1'b1, 8'h70, 8'h00);
      rd("ctrl", 8'h70, 8'h0f);
      for (int i = 0; i < 8; i++)
      begin
         seed = xs(seed);
         bus(1'b1, 8'h78, seed[7:0]);
         rd("prog", 8'h78, seed[7:0]);
         chk("prog_out", seed[7:0], {fb_mult, vco_range});
      end
      bus(1'b1, 8'h78, 8'h30);
      bus(1'b1, 8'h70, 8'h20);
      bus(1'b1, 8'h70, 8'h30);
      rd("ctrl", 8'h70, 8'h2f);
      chk("pll_run", 8'h0, {7'h0, pll_run});
      bus(1'b1, 8'h70, 8'h00);
      bus(1'b1, 8'h78, 8'h63);
      bus(1'b1, 8'h70, 8'h30);
      rd("ctrl", 8'h70, 8'h2f);
      bus(1'b1, 8'h70, 8'h10);
      rd("ctrl", 8'h70, 8'h0f);
      bus(1'b1, 8'h70, 8'h20);
      bus(1'b1, 8'h70, 8'h30);
      repeat (2) @(posedge clk);
      b = base;
      frozen = 1'b1;
      repeat (8)
      begin
         @(posedge clk);
         if (base !== b) frozen = 1'b0;
      end
      chk("frozen", 8'h1, {7'h0, frozen});
      rd("ctrl", 8'h70, 8'h3f);
      measure(8'd6);
      bus(1'b1, 8'h70, 8'h10);
      rd("ctrl", 8'h70, 8'h3f);
      bus(1'b1, 8'h74, 8'h80);
      bus(1'b1, 8'h70, 8'hb0);
      rd("ctrl", 8'h70, 8'hbf);
      chk("auto_bw", 8'h1, {7'h0, auto_bw});
      chk("acq_track", 8'h0, {7'h0, acq_tr});
      lock_req <= 1'b1;
      wait_irq(1'b1);
      rd("ctrl", 8'h70, 8'hff);
      rd("ctrl", 8'h70, 8'hbf);
      wait_irq(1'b0);
      rd("bw", 8'h74, 8'he0);
      lock_req <= 1'b0;
      wait_irq(1'b1);
      bus(1'b1, 8'h74, 8'h00);
      rd("ctrl", 8'h70, 8'h3f);
      chk("auto_bw", 8'h0, {7'h0, auto_bw});
      wait_irq(1'b0);
      rd("bw", 8'h74, 8'h00);
      bus(1'b1, 8'h70, 8'hb0);
      rd("ctrl", 8'h70, 8'h3f);
      lock_req <= 1'b1;
      repeat (12) @(posedge clk);
      chk("irq", 8'h0, {7'h0, irq});
      osc_en <= 1'b0;
      repeat (3) @(posedge clk);
      chk("base_stop", 8'h0, {7'h0, base});
      chk("osc_run", 8'h0, {7'h0, osc_run});
      chk("pll_run", 8'h0, {7'h0, pll_run});
      osc_en <= 1'b1;
      rd("ctrl", 8'h70, 8'h2f);
      measure(8'd8);
      test_done();
   end
endmodule : base_clock_selector_ctrl_bench
`default_nettype wire
